// >>> core/clkgen_cfg_pkg.sv
// constants and types for the clock generator configuration bank
package clkgen_cfg_pkg;
	localparam int unsigned CLK_HZ = 50_000_000;
	localparam int unsigned WD_UNIT_MS = 290;
	localparam int unsigned WD_UNIT_CYC = WD_UNIT_MS * (CLK_HZ / 1000);
	localparam logic [6:0] DEV_ADDR = 7'h5A;
	// arbitrary identification values
	localparam logic [2:0] VENDOR_CODE = 3'h5;
	localparam logic [4:0] REVISION_CODE = 5'h02;
	// byte indices
	localparam logic [4:0] IDX_PCI_EN = 5'h02;
	localparam logic [4:0] IDX_STRAP_A = 5'h04;
	localparam logic [4:0] IDX_PERIPH_EN = 5'h05;
	localparam logic [4:0] IDX_UNUSED6 = 5'h06;
	localparam logic [4:0] IDX_MAKER_REV = 5'h07;
	localparam logic [4:0] IDX_RB_LEN = 5'h08;
	localparam logic [4:0] IDX_WD_CTRL = 5'h09;
	localparam logic [4:0] IDX_WD_COUNT = 5'h0A;
	localparam logic [4:0] IDX_REF_DIV = 5'h0B;
	localparam logic [4:0] IDX_FB_DIV = 5'h0C;
	localparam logic [4:0] IDX_SPREAD_LO = 5'h0D;
	localparam logic [4:0] IDX_SPREAD_HI = 5'h0E;
	localparam logic [4:0] IDX_SKEW_A = 5'h0F;
	localparam logic [4:0] IDX_SKEW_B = 5'h10;
	localparam logic [4:0] IDX_SLEW_A = 5'h11;
	localparam logic [4:0] IDX_LAST = 5'h11;
	// field positions
	localparam int PCI_FREE_BIT = 6;
	localparam int APIC_BIT = 4;
	localparam int REFERENCE_OUT_ONE_BIT = 1;
	localparam int REFERENCE_OUT_ZERO_BIT = 0;
	localparam int STRAP_S1_BIT = 3;
	localparam int STRAP_S3_BIT = 1;
	localparam int SRC_SEL_BIT = 7;
	localparam int WD_EN_BIT = 6;
	localparam int WD_ALARM_BIT = 5;
	// reset values
	localparam logic [7:0] RST_PCI_EN = 8'hFF;
	localparam logic [7:0] RST_PERIPH_EN = 8'hFF;
	localparam logic [7:0] RST_UNUSED6 = 8'h06;
	localparam logic [7:0] RST_RB_LEN = 8'h08;
	localparam logic [7:0] RST_WD_CTRL = 8'h00;
	localparam logic [7:0] RST_WD_COUNT = 8'h10;
	localparam logic [7:0] DEF_SPREAD_LO = 8'h00;
	localparam logic [7:0] DEF_SPREAD_HI = 8'h00;
	localparam logic [7:0] DEF_SKEW_A = 8'h00;
	localparam logic [7:0] DEF_SKEW_B = 8'h00;
	localparam logic [7:0] DEF_SLEW_A = 8'h00;
	// writable masks, fixed reserved bits and divider offsets
	localparam logic [7:0] WM_PCI_EN = 8'h5F;
	localparam logic [7:0] FIX_PCI_EN = 8'hA0;
	localparam logic [7:0] WM_PERIPH_EN = 8'h13;
	localparam logic [7:0] FIX_PERIPH_EN = 8'hEC;
	localparam logic [7:0] FIX_STRAP_A = 8'hF5;
	localparam logic [7:0] WM_WD_CTRL = 8'hDF;
	localparam logic [7:0] WM_SPREAD_HI = 8'h1F;
	localparam logic [7:0] WM_SKEW_B = 8'hC0;
	localparam logic [9:0] FB_OFFSET = 10'h008;
	localparam logic [7:0] REF_OFFSET = 8'h02;

	typedef struct packed {
		logic wr;
		logic [4:0] idx;
		logic [7:0] data;
	} cfg_req_t;

	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_ADDR = 6'h02,
		ST_CMD = 6'h04,
		ST_COUNT = 6'h08,
		ST_WRITE = 6'h10,
		ST_READ = 6'h20
	} ser_state_t;
endpackage

// >>> core/clkgen_cfg.sv
// two-wire programmed configuration bank of the system clock generator
`timescale 1ns/100ps
module clkgen_cfg
	import clkgen_cfg_pkg::*;
#(
	parameter int unsigned WD_UNIT_CYCLES = WD_UNIT_CYC
) (
	input wire logic mclk_in,
	input wire logic nrst_in,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_out,
	input wire logic [3:0] freq_select_in,
	input wire logic pci_src_in,
	input wire logic ref_src_in,
	input wire logic apic_src_in,
	output logic pci_free_running_out,
	output logic pci_out_zero,
	output logic pci_out_one,
	output logic pci_out_two,
	output logic pci_out_three,
	output logic pci_out_four,
	output logic interrupt_ctrl_clock_out,
	output logic reference_out_zero,
	output logic reference_out_one,
	output logic [4:0] freq_code_out,
	output logic use_dividers_out,
	output logic [9:0] fb_div_out,
	output logic [7:0] ref_div_out,
	output logic [12:0] spread_out,
	output logic [7:0] skew_a_out,
	output logic [1:0] skew_b_out,
	output logic [7:0] slew_out,
	output logic wd_alarm_out
);

	// ----------------------------------------
	// functions
	// ----------------------------------------
	function automatic logic [17:0] freq_table(input logic [4:0] code);
		logic [17:0] v;
		v = {10'd447, 8'd40};
		case (code)
			5'h00: v = {10'd447, 8'd40};
			5'h01: v = {10'd440, 8'd42};
			5'h02: v = {10'd512, 8'd44};
			5'h03: v = {10'd392, 8'd42};
			5'h04: v = {10'd446, 8'd31};
			5'h05: v = {10'd485, 8'd31};
			5'h06: v = {10'd513, 8'd54};
			5'h07: v = {10'd518, 8'd37};
			5'h08: v = {10'd352, 8'd21};
			5'h09: v = {10'd514, 8'd32};
			5'h0A: v = {10'd507, 8'd33};
			5'h0B: v = {10'd484, 8'd33};
			5'h0C: v = {10'd352, 8'd18};
			5'h0D: v = {10'd440, 8'd21};
			5'h0E: v = {10'd433, 8'd25};
			5'h0F: v = {10'd483, 8'd26};
			5'h10: v = {10'd396, 8'd21};
			5'h11: v = {10'd345, 8'd19};
			5'h12: v = {10'd440, 8'd25};
			5'h13: v = {10'd478, 8'd29};
			5'h14: v = {10'd486, 8'd30};
			5'h15: v = {10'd491, 8'd37};
			5'h16: v = {10'd440, 8'd35};
			5'h17: v = {10'd463, 8'd39};
			5'h18: v = {10'd371, 8'd16};
			5'h19: v = {10'd447, 8'd20};
			5'h1A: v = {10'd433, 8'd20};
			5'h1B: v = {10'd310, 8'd15};
			5'h1C: v = {10'd469, 8'd23};
			5'h1D: v = {10'd362, 8'd18};
			5'h1E: v = {10'd476, 8'd24};
			5'h1F: v = {10'd347, 8'd18};
			default: v = {10'd447, 8'd40};
		endcase
		return v;
	endfunction

	function automatic logic [7:0] wmask(input logic [4:0] idx);
		logic [7:0] m;
		m = 8'h00;
		case (idx)
			IDX_PCI_EN: m = WM_PCI_EN;
			IDX_PERIPH_EN: m = WM_PERIPH_EN;
			IDX_WD_CTRL: m = WM_WD_CTRL;
			IDX_SPREAD_HI: m = WM_SPREAD_HI;
			IDX_SKEW_B: m = WM_SKEW_B;
			IDX_UNUSED6, IDX_RB_LEN, IDX_WD_COUNT, IDX_REF_DIV, IDX_FB_DIV,
			IDX_SPREAD_LO, IDX_SKEW_A, IDX_SLEW_A: m = 8'hFF;
			default: m = 8'h00;
		endcase
		return m;
	endfunction

	function automatic logic [7:0] reset_val(input logic [4:0] idx);
		logic [7:0] r;
		r = 8'h00;
		case (idx)
			IDX_PCI_EN: r = RST_PCI_EN;
			IDX_PERIPH_EN: r = RST_PERIPH_EN;
			IDX_UNUSED6: r = RST_UNUSED6;
			IDX_RB_LEN: r = RST_RB_LEN;
			IDX_WD_CTRL: r = RST_WD_CTRL;
			IDX_WD_COUNT: r = RST_WD_COUNT;
			default: r = 8'h00;
		endcase
		return r;
	endfunction

	// ----------------------------------------
	// storage and state
	// ----------------------------------------
	logic [7:0] cfg [0:17];
	logic [3:0] strap_code;
	logic strap_done;
	logic scl_q, sda_q;
	ser_state_t state;
	logic [3:0] bit_cnt;
	logic [7:0] shreg;
	logic [4:0] ptr;
	logic cnt_sent;
	cfg_req_t req;
	logic [23:0] tick_div;
	logic [7:0] wd_ticks;
	logic wd_alarm;

	// ----------------------------------------
	// decode
	// ----------------------------------------
	wire start_ev = scl_in & scl_q & sda_q & ~sda_in;
	wire stop_ev = scl_in & scl_q & ~sda_q & sda_in;
	wire scl_rise = scl_in & ~scl_q;
	wire scl_fall = ~scl_in & scl_q;
	wire is_read = (state == ST_READ);
	wire [7:0] pci_en = cfg[2] | FIX_PCI_EN;
	wire [7:0] periph_en = cfg[5] | FIX_PERIPH_EN;
	wire [7:0] wd_ctrl = {cfg[9][7:6], wd_alarm, cfg[9][4:0]};
	wire [7:0] strap_byte = FIX_STRAP_A | {4'h0, ~strap_code[1], 1'b0, ~strap_code[3], 1'b0};
	wire [7:0] id_byte = {VENDOR_CODE, REVISION_CODE};
	wire wd_en = cfg[9][WD_EN_BIT];
	wire src_prog = cfg[9][SRC_SEL_BIT];
	wire [4:0] strap5 = {1'b0, strap_code};
	wire [4:0] next_freq_code = wd_alarm ? cfg[9][4:0] : strap5;
	wire next_use_div = src_prog & ~wd_alarm;
	wire [17:0] tbl_active = freq_table(next_freq_code);
	// straps still being captured, so read the pins directly
	wire [17:0] tbl_strap = freq_table({1'b0, freq_select_in});
	wire [9:0] prog_fb = {1'b0, cfg[12], cfg[11][7]} + FB_OFFSET;
	wire [7:0] prog_ref = {1'b0, cfg[11][6:0]} + REF_OFFSET;
	wire [9:0] next_fb = next_use_div ? prog_fb : tbl_active[17:8];
	wire [7:0] next_ref = next_use_div ? prog_ref : tbl_active[7:0];
	wire idx_ok = (ptr <= IDX_LAST);
	wire [7:0] rd_stored = idx_ok ? (cfg[ptr] & wmask(ptr)) : 8'h00;
	wire [7:0] rd_byte = (ptr == IDX_PCI_EN) ? pci_en :
		(ptr == IDX_PERIPH_EN) ? periph_en :
		(ptr == IDX_STRAP_A) ? strap_byte :
		(ptr == IDX_MAKER_REV) ? id_byte :
		(ptr == IDX_WD_CTRL) ? wd_ctrl : rd_stored;
	wire [7:0] tx_byte = cnt_sent ? rd_byte : cfg[8];
	wire addr_hit = (shreg[7:1] == DEV_ADDR);
	wire wd_kick = req.wr & ((req.idx == IDX_WD_CTRL) | (req.idx == IDX_WD_COUNT));
	wire wd_clear = req.wr & (req.idx == IDX_WD_CTRL) & ~req.data[WD_ALARM_BIT];
	wire wd_tick = (tick_div == 24'(WD_UNIT_CYCLES - 1));
	wire wd_expire = wd_en & ~wd_alarm & (wd_ticks == cfg[10]);

	// ----------------------------------------
	// serial slave
	// ----------------------------------------
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			state <= ST_IDLE;
			bit_cnt <= 4'h0;
			shreg <= 8'h00;
			ptr <= 5'h00;
			cnt_sent <= 1'b0;
			sda_oe_out <= 1'b0;
			req <= '0;
		end else begin
			scl_q <= scl_in;
			sda_q <= sda_in;
			req.wr <= 1'b0;
			if (start_ev) begin
				state <= ST_ADDR;
				// clock fall closing the start wraps this to zero
				bit_cnt <= 4'hF;
				sda_oe_out <= 1'b0;
			end else if (stop_ev) begin
				state <= ST_IDLE;
				sda_oe_out <= 1'b0;
			end else if (state != ST_IDLE) begin
				if (scl_rise && bit_cnt < 4'h8 && !is_read) begin
					shreg <= {shreg[6:0], sda_in};
				end
				if (scl_rise && bit_cnt == 4'h8 && is_read && sda_in) begin
					state <= ST_IDLE;
					sda_oe_out <= 1'b0;
				end
				if (scl_fall) begin
					if (bit_cnt == 4'h7) begin
						bit_cnt <= 4'h8;
						sda_oe_out <= 1'b0;
						unique case (state)
							ST_ADDR: begin
								sda_oe_out <= addr_hit;
								state <= !addr_hit ? ST_IDLE : (shreg[0] ? ST_READ : ST_CMD);
								ptr <= 5'h00;
								cnt_sent <= 1'b0;
							end
							ST_CMD: begin
								sda_oe_out <= 1'b1;
								state <= ST_COUNT;
							end
							ST_COUNT: begin
								sda_oe_out <= 1'b1;
								state <= ST_WRITE;
							end
							ST_WRITE: begin
								sda_oe_out <= 1'b1;
								req <= '{wr: 1'b1, idx: ptr, data: shreg};
								if (ptr != 5'h1F) ptr <= ptr + 5'h01;
							end
							ST_READ: sda_oe_out <= 1'b0;
							ST_IDLE: sda_oe_out <= 1'b0;
						endcase
					end else if (bit_cnt == 4'h8) begin
						bit_cnt <= 4'h0;
						sda_oe_out <= is_read & ~tx_byte[7];
						if (is_read) begin
							shreg <= tx_byte;
							cnt_sent <= 1'b1;
							if (cnt_sent && ptr != 5'h1F) ptr <= ptr + 5'h01;
						end
					end else begin
						bit_cnt <= bit_cnt + 4'h1;
						if (is_read) begin
							sda_oe_out <= ~shreg[6];
							shreg <= {shreg[6:0], 1'b0};
						end
					end
				end
			end
		end
	end

	// ----------------------------------------
	// register bank
	// ----------------------------------------
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			for (int i = 0; i <= 17; i++) cfg[i] <= reset_val(5'(i));
			strap_code <= 4'h0;
			strap_done <= 1'b0;
		end else if (!strap_done) begin
			strap_code <= freq_select_in;
			strap_done <= 1'b1;
			cfg[11] <= {tbl_strap[8] ^ FB_OFFSET[0], tbl_strap[6:0] - REF_OFFSET[6:0]};
			cfg[12] <= 8'((tbl_strap[17:8] - FB_OFFSET) >> 1);
			cfg[13] <= DEF_SPREAD_LO;
			cfg[14] <= DEF_SPREAD_HI;
			cfg[15] <= DEF_SKEW_A;
			cfg[16] <= DEF_SKEW_B;
			cfg[17] <= DEF_SLEW_A;
		end else if (req.wr && req.idx <= IDX_LAST) begin
			cfg[req.idx] <= (req.data & wmask(req.idx)) | (cfg[req.idx] & ~wmask(req.idx));
		end
	end

	// ----------------------------------------
	// watchdog
	// ----------------------------------------
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			tick_div <= 24'h000000;
			wd_ticks <= 8'h00;
			wd_alarm <= 1'b0;
		end else begin
			if (!wd_en || wd_kick || wd_alarm) begin
				tick_div <= 24'h000000;
				wd_ticks <= 8'h00;
			end else begin
				tick_div <= wd_tick ? 24'h000000 : tick_div + 24'h000001;
				if (wd_tick && wd_ticks != 8'hFF) wd_ticks <= wd_ticks + 8'h01;
			end
			if (wd_expire) wd_alarm <= 1'b1;
			else if (wd_clear) wd_alarm <= 1'b0;
		end
	end

	// ----------------------------------------
	// registered outputs
	// ----------------------------------------
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			sda_out <= 1'b0;
			{pci_free_running_out, pci_out_four, pci_out_three, pci_out_two, pci_out_one, pci_out_zero} <= 6'h00;
			{interrupt_ctrl_clock_out, reference_out_one, reference_out_zero} <= 3'h0;
			freq_code_out <= 5'h00;
			use_dividers_out <= 1'b0;
			fb_div_out <= 10'h000;
			ref_div_out <= 8'h00;
			spread_out <= 13'h0000;
			skew_a_out <= 8'h00;
			skew_b_out <= 2'h0;
			slew_out <= 8'h00;
			wd_alarm_out <= 1'b0;
		end else begin
			sda_out <= 1'b0;
			pci_free_running_out <= pci_src_in & pci_en[PCI_FREE_BIT];
			pci_out_zero <= pci_src_in & pci_en[0];
			pci_out_one <= pci_src_in & pci_en[1];
			pci_out_two <= pci_src_in & pci_en[2];
			pci_out_three <= pci_src_in & pci_en[3];
			pci_out_four <= pci_src_in & pci_en[4];
			interrupt_ctrl_clock_out <= apic_src_in & periph_en[APIC_BIT];
			reference_out_one <= ref_src_in & periph_en[REFERENCE_OUT_ONE_BIT];
			reference_out_zero <= ref_src_in & periph_en[REFERENCE_OUT_ZERO_BIT];
			freq_code_out <= next_freq_code;
			use_dividers_out <= next_use_div;
			fb_div_out <= next_fb;
			ref_div_out <= next_ref;
			spread_out <= {cfg[14][4:0], cfg[13]};
			skew_a_out <= cfg[15];
			skew_b_out <= cfg[16][7:6];
			slew_out <= cfg[17];
			wd_alarm_out <= wd_alarm;
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!nrst_in);

	AST_PCI_GATE: assert property (!pci_en[0] |=> !pci_out_zero)
		else $error("disabled pci output switched");
	AST_FREE_MAP: assert property (pci_src_in && pci_en[PCI_FREE_BIT] |=> pci_free_running_out)
		else $error("free-running pci output not following source");
	AST_APIC_GATE: assert property (!periph_en[APIC_BIT] |=> !interrupt_ctrl_clock_out)
		else $error("disabled interrupt clock switched");
	AST_STRAP_INV: assert property (strap_done |-> strap_byte[STRAP_S1_BIT] == ~strap_code[1]
		&& strap_byte[STRAP_S3_BIT] == ~strap_code[3])
		else $error("strap readback not inverted");
	AST_ID_FIXED: assert property (##1 $stable(id_byte))
		else $error("identification byte changed");
	AST_SRC_SEL: assert property (src_prog && !wd_alarm |=> use_dividers_out && ref_div_out == $past(prog_ref))
		else $error("programmed divider source not applied");
	AST_WD_OFF: assert property (!wd_en |=> wd_ticks == 8'h00)
		else $error("watchdog counted while disabled");
	AST_ALARM_BIT: assert property (wd_ctrl[WD_ALARM_BIT] == wd_alarm)
		else $error("alarm status bit mismatch");
	AST_WD_TIME: assert property ($rose(wd_alarm) |-> $past(wd_ticks) == $past(cfg[10]))
		else $error("alarm raised before timeout count");
	AST_SAFE: assert property (wd_alarm |=> freq_code_out == $past(cfg[9][4:0]) && !use_dividers_out)
		else $error("safe frequency not applied in alarm");
	AST_REF: assert property (next_use_div |=> ref_div_out == $past({1'b0, cfg[11][6:0]}) + REF_OFFSET)
		else $error("reference divider offset wrong");
	AST_FB: assert property (next_use_div |=> fb_div_out == $past({1'b0, cfg[12], cfg[11][7]}) + FB_OFFSET)
		else $error("feedback divider offset wrong");
	AST_RSVD: assert property (pci_en[7] && pci_en[5] && periph_en[7:5] == 3'h7)
		else $error("reserved enable bits not reading one");

	COV_WRITE: cover property (req.wr && req.idx == IDX_PCI_EN);
	COV_READ: cover property (is_read && cnt_sent && scl_fall && bit_cnt == 4'h8);
	COV_ALARM: cover property ($rose(wd_alarm));
	COV_PROG: cover property ($rose(use_dividers_out));

endmodule

// >>> tb/two_wire_host.sv
// two-wire host model driving the serial configuration port
`timescale 1ns/100ps
module two_wire_host (
	input wire logic mclk_in,
	input wire logic sda_in,
	output logic scl_out,
	output logic sda_out
);
	// bus idles released, clock stands high outside frames
	initial begin
		scl_out = 1'b1;
		sda_out = 1'b1;
	end
	// ------------------------------------------------------------
	// bus phases, four clocks each, changed just after an edge
	// ------------------------------------------------------------
	task automatic half();
		repeat (4) @(posedge mclk_in);
		#1;
	endtask
	task automatic start();
		sda_out = 1'b0;
		half();
		scl_out = 1'b0;
		half();
	endtask
	task automatic xfer_bit(input logic b, output logic r);
		sda_out = b;
		half();
		scl_out = 1'b1;
		half();
		r = sda_in;
		scl_out = 1'b0;
		half();
	endtask
	// msb first, ninth bit is the acknowledge slot
	task automatic xfer_byte(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack_seen);
		for (int i = 7; i >= 0; i--) begin
			xfer_bit(d[i], q[i]);
		end
		xfer_bit(ack_in, ack_seen);
	endtask
	task automatic stop();
		sda_out = 1'b0;
		half();
		scl_out = 1'b1;
		half();
		sda_out = 1'b1;
		half();
	endtask
endmodule

// >>> tb/tb_clkgen_cfg.sv
// self-checking bench for the clock generator configuration bank
`timescale 1ns/100ps
module tb_clkgen_cfg;
	import clkgen_cfg_pkg::*;
	localparam int unsigned UNIT = 10;
	logic mclk_in = 1'b0;
	logic nrst_in = 1'b0;
	logic [3:0] straps = 4'h6;
	logic [2:0] src = 3'h0;
	logic scl;
	logic host_sda;
	logic sda_q;
	logic sda_oe;
	wire sda_wire;
	logic [8:0] gated;
	logic [4:0] freq_code;
	logic use_div;
	logic alarm;
	logic [9:0] fb_div;
	logic [7:0] ref_div;
	logic [12:0] spread;
	logic [7:0] skew_a;
	logic [1:0] skew_b;
	logic [7:0] slew;
	logic [7:0] img [0:17];
	logic [7:0] exp_v [0:17];
	logic [7:0] rd [0:17];
	logic [7:0] rd_count;
	int fail_count = 0;
	int tests_run = 0;
	int cycles = 0;
	always #10 mclk_in = ~mclk_in;
	// pulled-up data wire
	assign sda_wire = host_sda & ~(sda_oe & ~sda_q);
	clkgen_cfg #(.WD_UNIT_CYCLES(UNIT)) u_clkgen_cfg (
		.mclk_in(mclk_in), .nrst_in(nrst_in), .scl_in(scl), .sda_in(sda_wire),
		.sda_out(sda_q), .sda_oe_out(sda_oe), .freq_select_in(straps),
		.pci_src_in(src[2]), .ref_src_in(src[1]), .apic_src_in(src[0]),
		.pci_free_running_out(gated[8]), .pci_out_four(gated[7]), .pci_out_three(gated[6]),
		.pci_out_two(gated[5]), .pci_out_one(gated[4]), .pci_out_zero(gated[3]),
		.interrupt_ctrl_clock_out(gated[2]), .reference_out_one(gated[1]), .reference_out_zero(gated[0]),
		.freq_code_out(freq_code), .use_dividers_out(use_div), .fb_div_out(fb_div),
		.ref_div_out(ref_div), .spread_out(spread), .skew_a_out(skew_a), .skew_b_out(skew_b),
		.slew_out(slew), .wd_alarm_out(alarm)
	);
	two_wire_host u_two_wire_host (.mclk_in(mclk_in), .sda_in(sda_wire), .scl_out(scl), .sda_out(host_sda));
	// ------------------------------------------------------------
	// checking and closing
	// ------------------------------------------------------------
	task automatic check_reg(input string what, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic check_out(input string what, input logic [15:0] e, input logic [15:0] g);
		tests_run++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic test_done();
		if (fail_count == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	always @(posedge mclk_in) begin
		cycles++;
		if (cycles == 40000) begin
			fail_count++;
			test_done();
		end
	end
	// ------------------------------------------------------------
	// serial transfers
	// ------------------------------------------------------------
	task automatic put_byte(input logic [7:0] d);
		logic [7:0] q;
		logic a;
		u_two_wire_host.xfer_byte(d, 1'b1, q, a);
		check_out("ack", 16'h0, {15'h0, a});
	endtask
	// command and count bytes are ignored, data starts at byte 0
	task automatic write_upto(input int last);
		u_two_wire_host.start();
		put_byte({DEV_ADDR, 1'b0});
		put_byte(8'h00);
		put_byte(8'h00);
		for (int i = 0; i <= last; i++) begin
			put_byte(img[i]);
		end
		u_two_wire_host.stop();
	endtask
	// count byte arrives first, then bytes 0 to 17
	task automatic read_all();
		logic a;
		u_two_wire_host.start();
		put_byte({DEV_ADDR, 1'b1});
		u_two_wire_host.xfer_byte(8'hFF, 1'b0, rd_count, a);
		for (int i = 0; i <= 17; i++) begin
			u_two_wire_host.xfer_byte(8'hFF, i == 17, rd[i], a);
		end
		u_two_wire_host.stop();
	endtask
	task automatic check_bytes(input logic [17:0] mask);
		for (int i = 0; i <= 17; i++) begin
			if (mask[i]) begin
				check_reg($sformatf("byte %0d", i), exp_v[i], rd[i]);
			end
		end
	endtask
	task automatic check_gate(input logic [8:0] en);
		src = 3'h7;
		repeat (2) @(posedge mclk_in);
		#1;
		check_out("gated high", {7'h0, en}, {7'h0, gated});
		src = 3'h0;
		repeat (2) @(posedge mclk_in);
		#1;
		check_out("gated low", 16'h0, {7'h0, gated});
	endtask
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic test_reset();
		read_all();
		exp_v = '{8'h00, 8'h00, RST_PCI_EN, 8'h00, FIX_STRAP_A | {4'h0, ~straps[1], 1'b0, ~straps[3], 1'b0},
			RST_PERIPH_EN, RST_UNUSED6, {VENDOR_CODE, REVISION_CODE}, RST_RB_LEN, RST_WD_CTRL, RST_WD_COUNT,
			8'hB4, 8'hFC, DEF_SPREAD_LO, DEF_SPREAD_HI, DEF_SKEW_A, DEF_SKEW_B, DEF_SLEW_A};
		check_bytes(18'h3FFFF);
		check_reg("count first", RST_RB_LEN, rd_count);
		check_out("code", {11'h0, 1'b0, straps}, {11'h0, freq_code});
		check_out("dividers used", 16'h0, {15'h0, use_div});
		// strap code 6 selects feedback 513 over reference 54
		check_out("strap fb div", 16'h0201, {6'h0, fb_div});
		check_out("strap ref div", 16'h0036, {8'h0, ref_div});
		check_out("alarm", 16'h0, {15'h0, alarm});
		check_gate(9'h1FF);
	endtask
	task automatic test_gating();
		img = '{8'h00, 8'h00, 8'h05, 8'h00, 8'h00, 8'h02, 8'h39, 8'h00, 8'h19, 8'h00, 8'h10,
			8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
		write_upto(10);
		exp_v[2] = 8'h05 | FIX_PCI_EN;
		exp_v[5] = 8'h02 | FIX_PERIPH_EN;
		exp_v[6] = 8'h39;
		exp_v[8] = 8'h19;
		read_all();
		check_bytes(18'h3E7FF);
		check_reg("count first", 8'h19, rd_count);
		check_gate(9'h02A);
	endtask
	task automatic test_dividers();
		img[9] = 8'h80;
		img[11] = 8'hA5;
		img[12] = 8'h1C;
		for (int i = 13; i <= 17; i++) begin
			img[i] = rd[i];
		end
		write_upto(17);
		img[13] = 8'h3C;
		img[14] = 8'hFB;
		img[15] = 8'hC9;
		img[16] = 8'hD5;
		img[17] = 8'h6E;
		write_upto(17);
		exp_v[9] = 8'h80;
		exp_v[10] = 8'h10;
		exp_v[11] = 8'hA5;
		exp_v[12] = 8'h1C;
		exp_v[13] = 8'h3C;
		exp_v[14] = 8'hFB & WM_SPREAD_HI;
		exp_v[15] = 8'hC9;
		exp_v[16] = 8'hD5 & WM_SKEW_B;
		exp_v[17] = 8'h6E;
		read_all();
		check_bytes(18'h3FFFF);
		check_out("dividers used", 16'h1, {15'h0, use_div});
		check_out("ref div", {8'h0, {1'b0, img[11][6:0]} + REF_OFFSET}, {8'h0, ref_div});
		check_out("fb div", {6'h0, {1'b0, img[12], img[11][7]} + FB_OFFSET}, {6'h0, fb_div});
		check_out("spread", {3'h0, img[14][4:0], img[13]}, {3'h0, spread});
		check_out("skew", {6'h0, img[16][7:6], img[15]}, {6'h0, skew_b, skew_a});
		check_out("slew", {8'h0, img[17]}, {8'h0, slew});
	endtask
	task automatic test_watchdog();
		int n;
		img[9] = 8'hCB;
		img[10] = 8'h08;
		write_upto(10);
		check_out("alarm early", 16'h0, {15'h0, alarm});
		n = 0;
		while (alarm !== 1'b1 && n < 100) begin
			@(posedge mclk_in);
			#1;
			n++;
		end
		// count restarts at the byte 10 write, about 26 clocks before return
		check_out("alarm delay", 16'h1, {15'h0, n >= 50 && n <= 62});
		check_out("safe code", 16'h000B, {11'h0, freq_code});
		check_out("dividers used", 16'h0, {15'h0, use_div});
		exp_v[9] = 8'hCB | 8'h20;
		exp_v[10] = 8'h08;
		read_all();
		check_bytes(18'h00600);
	endtask
	initial begin
		repeat (2) @(posedge mclk_in);
		#1;
		nrst_in = 1'b1;
		repeat (2) @(posedge mclk_in);
		#1;
		test_reset();
		test_gating();
		test_dividers();
		test_watchdog();
		test_done();
	end
endmodule
